//--- rtl/ctw_defs.svh
// Offsets, field positions, reset values and timing counts of the supervision block.
`ifndef CTW_DEFS_SVH
`define CTW_DEFS_SVH

// Register word addresses.
`define CTW_ADDR_CTRL 4'h0
`define CTW_ADDR_HIGH 4'h1
`define CTW_ADDR_LOW 4'h2
`define CTW_ADDR_MINMAX 4'h3
`define CTW_ADDR_SEQ 4'h4
`define CTW_ADDR_DIFF 4'h5
`define CTW_ADDR_DELAY 4'h6
`define CTW_ADDR_STATUS 4'h7
`define CTW_ADDR_DIFF_MAG 4'h8
`define CTW_ADDR_NAT_ANG 4'h9
`define CTW_ADDR_DIFF_ANG 4'ha

// Control register fields.
`define CTW_CTRL_SEL_LSB 0
`define CTW_CTRL_SUB_BIT 2
`define CTW_CTRL_COMP_BIT 3

// Reset values, currents in 0.01 x nominal, ratios in 0.01 percent, delay in program cycles.
`define CTW_RST_HIGH 16'h0078
`define CTW_RST_LOW 16'h000a
`define CTW_RST_MINMAX 16'h03e8
`define CTW_RST_SEQ 16'h1324
`define CTW_RST_DIFF 16'h000a
`define CTW_RST_DELAY 19'h0_0064

// Hysteresis release factors in percent, and the 0.01 percent ratio scale.
`define CTW_HYS_SCALE 48'h0000_0000_0064
`define CTW_HYS_DOWN 48'h0000_0000_0061
`define CTW_HYS_UP 48'h0000_0000_0067
`define CTW_PCT_SCALE 48'h0000_0000_2710

// Largest readable difference magnitude, 50.00 x nominal.
`define CTW_DIFF_MAX 19'h0_1388

// Program cycle length and clock rate.
`define CTW_CYCLE_US 5000
`define CTW_CLK_MHZ 50

`endif

//--- rtl/ctw_pkg.sv
// Types shared by the supervision block and its users.
package ctw_pkg;

  // Fundamental-frequency measurements from the front end, currents in 0.01 x nominal.
  typedef struct packed {
    logic [2:0][15:0] phase_mag;
    logic [15:0] pos_mag;
    logic [15:0] neg_mag;
    logic [2:0][15:0] phase_re;
    logic [2:0][15:0] phase_im;
    logic [15:0] res1_re;
    logic [15:0] res1_im;
    logic [15:0] res2_re;
    logic [15:0] res2_im;
    logic [16:0] sum_ang;
    logic [16:0] res1_ang;
    logic [16:0] res2_ang;
  } ctw_meas_type;

  // Supervision states.
  typedef enum logic [3:0] {
    CTW_IDLE = 4'b0001,
    CTW_TIMING = 4'b0010,
    CTW_ALARM = 4'b0100,
    CTW_BLOCKED = 4'b1000
  } ctw_state_type;

  // Residual input selection.
  typedef enum logic [1:0] {
    CTW_RES_NONE = 2'b00,
    CTW_RES_ONE = 2'b01,
    CTW_RES_TWO = 2'b10
  } ctw_res_sel_type;

endpackage

//--- rtl/ctw_isqrt.sv
// Bit-serial integer square root for phasor magnitudes.
`timescale 1ns/100ps
module ctw_isqrt (
  input wire logic clk_in, // System clock.
  input wire logic rstn_in, // Synchronous reset, active low.
  input wire logic start_in, // One-cycle pulse that starts a root.
  input wire logic [37:0] value_in, // Radicand.
  output logic [18:0] root_out, // Root, valid with done.
  output logic done_out // One-cycle pulse when root is ready.
);

  logic [37:0] op_reg;
  logic [37:0] res_reg;
  logic [37:0] one_reg;
  logic busy_reg;
  logic [37:0] trial;

  // Trial subtraction of the current bit.
  assign trial = res_reg + one_reg;

  // One result bit per clock, nineteen clocks per root.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      op_reg <= '0;
      res_reg <= '0;
      one_reg <= '0;
      busy_reg <= 1'b0;
      root_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        op_reg <= value_in;
        res_reg <= '0;
        one_reg <= 38'h10_0000_0000;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (op_reg >= trial) begin
          op_reg <= op_reg - trial;
          res_reg <= (res_reg >> 1) + one_reg;
        end else begin
          res_reg <= res_reg >> 1;
        end
        one_reg <= one_reg >> 2;
        if (one_reg == 38'h00_0000_0001) begin
          busy_reg <= 1'b0;
          done_out <= 1'b1;
          root_out <= (op_reg >= trial) ? 19'((res_reg >> 1) + one_reg) : 19'(res_reg >> 1);
        end
      end
    end
  end

endmodule

//--- rtl/ctw_supervisor.sv
// Current transformer wiring supervision with hysteresis, definite delay and blocking.
// How it works
// - Every threshold releases at 97 or 103 percent of its setting.
// - One threshold setting is compared against every phase current channel.
// - Pick-up needs at least one phase above and at least one phase below the threshold.
// - Any phase above the upper limit marks a network fault and inhibits supervision.
// - At least one phase must exceed the lower limit before activation.
// - Minimum to maximum phase ratio must stay below its setting.
// - Negative to positive sequence ratio must exceed its setting.
// - With residual in use, summed minus measured residual must exceed setting.
// - Alarm follows activation after the settable delay in 5 ms steps.
// - Setting writes take effect live without restarting supervision.
// - Blocking input is sampled once per program cycle and held.
// - Pick-up without blocking raises start and runs the alarm delay.
// - Pick-up with blocking raises blocked and nothing more is done.
// - Blocking after start clears start and releases like pick-up drop.
// - Only the definite delay characteristic exists.
// - Summed-to-residual magnitude difference is readable, 0.00 to 50.00 x nominal.
// - Natural unbalance angle and summed-to-residual angle difference are readable.
// - Alarm needs all enabled conditions together, held through the delay.
// - Residual selection is none, channel one or channel two.
// - The selected residual channel is added or subtracted by polarity.
// - Compensation command captures the calculated residual and subtracts it later.
`timescale 1ns/100ps
`include "ctw_defs.svh"
module ctw_supervisor #(
  parameter int CYCLE_CLKS = `CTW_CYCLE_US * `CTW_CLK_MHZ
) (
  input wire logic clk_in, // System clock, 50 MHz.
  input wire logic rstn_in, // Synchronous reset, active low.
  input wire ctw_pkg::ctw_meas_type meas_in, // Measurements, same clock domain.
  input wire logic block_in, // Blocking matrix input, asynchronous.
  input wire logic [3:0] addr_in, // Register word address.
  input wire logic [31:0] wdata_in, // Register write data.
  input wire logic wr_in, // Write strobe.
  input wire logic rd_in, // Read strobe.
  output logic [31:0] rdata_out, // Read data, one cycle after the strobe.
  output logic start_out, // Supervision started.
  output logic alarm_out, // Supervision alarm.
  output logic blocked_out // Pick-up seen while blocked.
);

  // Settings and control.
  logic [1:0] res_sel_reg;
  logic res_sub_reg;
  logic [15:0] high_reg;
  logic [15:0] low_reg;
  logic [15:0] minmax_reg;
  logic [15:0] seq_reg;
  logic [15:0] diff_reg;
  logic [18:0] delay_reg;
  logic comp_req_reg;

  // Compensation and readouts.
  logic signed [17:0] comp_re_reg;
  logic signed [17:0] comp_im_reg;
  logic signed [16:0] comp_ang_reg;
  logic [15:0] diff_mag_reg;
  logic signed [17:0] diff_ang_reg;

  // Program cycle divider and blocking sampling.
  logic [31:0] div_reg;
  logic tick_reg;
  logic blk_meta_reg;
  logic blk_sync_reg;
  logic blk_cycle_reg;

  // Condition flags with hysteresis memory.
  logic [2:0] hi_reg;
  logic [2:0] above_reg;
  logic [2:0] below_reg;
  logic minmax_ok_reg;
  logic seq_ok_reg;
  logic diff_ok_reg;
  logic [2:0] hi_next;
  logic [2:0] above_next;
  logic [2:0] below_next;
  logic minmax_ok_next;
  logic seq_ok_next;
  logic diff_ok_next;
  logic pickup_next;

  // Supervision state and delay timer.
  ctw_pkg::ctw_state_type state_reg;
  ctw_pkg::ctw_state_type state_next;
  logic [18:0] timer_reg;
  logic [18:0] timer_next;

  // Phasor arithmetic.
  logic signed [17:0] sum_re;
  logic signed [17:0] sum_im;
  logic signed [17:0] res_re;
  logic signed [17:0] res_im;
  logic signed [18:0] dif_re;
  logic signed [18:0] dif_im;
  logic [37:0] dif_sq;
  logic [15:0] max_mag;
  logic [15:0] min_mag;
  logic [18:0] root;
  logic root_done;

  // Set above the reference, hold while above 97 percent of it.
  function automatic logic over_hyst(input logic held, input logic [47:0] lhs, input logic [47:0] rhs);
    if (held) begin
      over_hyst = (lhs * `CTW_HYS_SCALE) > (rhs * `CTW_HYS_DOWN);
    end else begin
      over_hyst = lhs > rhs;
    end
  endfunction

  // Set below the reference, hold while below 103 percent of it.
  function automatic logic under_hyst(input logic held, input logic [47:0] lhs, input logic [47:0] rhs);
    if (held) begin
      under_hyst = (lhs * `CTW_HYS_SCALE) < (rhs * `CTW_HYS_UP);
    end else begin
      under_hyst = lhs < rhs;
    end
  endfunction

  // Program cycle tick every 5 ms, the time base of measurements and delay.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == 32'(CYCLE_CLKS - 1)) begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end

  // Blocking pin synchroniser and once-per-cycle sample.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      blk_meta_reg <= 1'b0;
      blk_sync_reg <= 1'b0;
      blk_cycle_reg <= 1'b0;
    end else begin
      blk_meta_reg <= block_in;
      blk_sync_reg <= blk_meta_reg;
      if (div_reg == 32'(CYCLE_CLKS - 1)) begin
        blk_cycle_reg <= blk_sync_reg;
      end
    end
  end

  // Settings writes land at once and are used from the next program cycle on.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      res_sel_reg <= ctw_pkg::CTW_RES_NONE;
      res_sub_reg <= 1'b0;
      high_reg <= `CTW_RST_HIGH;
      low_reg <= `CTW_RST_LOW;
      minmax_reg <= `CTW_RST_MINMAX;
      seq_reg <= `CTW_RST_SEQ;
      diff_reg <= `CTW_RST_DIFF;
      delay_reg <= `CTW_RST_DELAY;
      comp_req_reg <= 1'b0;
    end else begin
      comp_req_reg <= 1'b0;
      if (wr_in) begin
        unique case (addr_in)
          `CTW_ADDR_CTRL: begin
            res_sel_reg <= wdata_in[`CTW_CTRL_SEL_LSB +: 2];
            res_sub_reg <= wdata_in[`CTW_CTRL_SUB_BIT];
            comp_req_reg <= wdata_in[`CTW_CTRL_COMP_BIT];
          end
          `CTW_ADDR_HIGH: high_reg <= wdata_in[15:0];
          `CTW_ADDR_LOW: low_reg <= wdata_in[15:0];
          `CTW_ADDR_MINMAX: minmax_reg <= wdata_in[15:0];
          `CTW_ADDR_SEQ: seq_reg <= wdata_in[15:0];
          `CTW_ADDR_DIFF: diff_reg <= wdata_in[15:0];
          `CTW_ADDR_DELAY: delay_reg <= wdata_in[18:0];
          default: ;
        endcase
      end
    end
  end

  // Calculated residual from the phases, less the captured natural unbalance.
  always_comb begin
    sum_re = 18'(
      $signed(meas_in.phase_re[0]) + $signed(meas_in.phase_re[1]) + $signed(meas_in.phase_re[2])
    );
    sum_im = 18'(
      $signed(meas_in.phase_im[0]) + $signed(meas_in.phase_im[1]) + $signed(meas_in.phase_im[2])
    );
    if (res_sel_reg == ctw_pkg::CTW_RES_TWO) begin
      res_re = 18'($signed(meas_in.res2_re));
      res_im = 18'($signed(meas_in.res2_im));
    end else begin
      res_re = 18'($signed(meas_in.res1_re));
      res_im = 18'($signed(meas_in.res1_im));
    end
    if (res_sub_reg) begin
      dif_re = 19'(sum_re - comp_re_reg) - 19'(res_re);
      dif_im = 19'(sum_im - comp_im_reg) - 19'(res_im);
    end else begin
      dif_re = 19'(sum_re - comp_re_reg) + 19'(res_re);
      dif_im = 19'(sum_im - comp_im_reg) + 19'(res_im);
    end
    dif_sq = 38'(dif_re * dif_re) + 38'(dif_im * dif_im);
  end

  // Magnitude of the residual difference, one root per program cycle.
  ctw_isqrt u_isqrt (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .start_in(tick_reg),
    .value_in(dif_sq),
    .root_out(root),
    .done_out(root_done)
  );

  // Compensation capture and difference readouts.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      comp_re_reg <= '0;
      comp_im_reg <= '0;
      comp_ang_reg <= '0;
      diff_mag_reg <= '0;
      diff_ang_reg <= '0;
    end else begin
      if (comp_req_reg) begin
        comp_re_reg <= sum_re;
        comp_im_reg <= sum_im;
        comp_ang_reg <= $signed(meas_in.sum_ang);
      end
      if (root_done) begin
        diff_mag_reg <= (root > `CTW_DIFF_MAX) ? 16'(`CTW_DIFF_MAX) : root[15:0];
      end
      if (tick_reg) begin
        if (res_sel_reg == ctw_pkg::CTW_RES_TWO) begin
          diff_ang_reg <= 18'($signed(meas_in.sum_ang)) - 18'($signed(meas_in.res2_ang));
        end else begin
          diff_ang_reg <= 18'($signed(meas_in.sum_ang)) - 18'($signed(meas_in.res1_ang));
        end
      end
    end
  end

  // Largest and smallest phase magnitude.
  always_comb begin
    max_mag = meas_in.phase_mag[0];
    min_mag = meas_in.phase_mag[0];
    for (int i = 1; i < 3; i++) begin
      if (meas_in.phase_mag[i] > max_mag) begin
        max_mag = meas_in.phase_mag[i];
      end
      if (meas_in.phase_mag[i] < min_mag) begin
        min_mag = meas_in.phase_mag[i];
      end
    end
  end

  // Per-phase limit comparisons share the same settings.
  generate
    for (genvar p = 0; p < 3; p++) begin : g_phase
      assign hi_next[p] = over_hyst(hi_reg[p], 48'(meas_in.phase_mag[p]), 48'(high_reg));
      assign above_next[p] = over_hyst(above_reg[p], 48'(meas_in.phase_mag[p]), 48'(low_reg));
      assign below_next[p] = under_hyst(below_reg[p], 48'(meas_in.phase_mag[p]), 48'(low_reg));
    end
  endgenerate

  // Ratio conditions in 0.01 percent, residual condition in 0.01 x nominal.
  always_comb begin
    minmax_ok_next = under_hyst(
      minmax_ok_reg, 48'(min_mag) * `CTW_PCT_SCALE, 48'(minmax_reg) * 48'(max_mag)
    );
    seq_ok_next = over_hyst(
      seq_ok_reg, 48'(meas_in.neg_mag) * `CTW_PCT_SCALE, 48'(seq_reg) * 48'(meas_in.pos_mag)
    );
    diff_ok_next = (res_sel_reg != ctw_pkg::CTW_RES_NONE)
      && over_hyst(diff_ok_reg, 48'(diff_mag_reg), 48'(diff_reg));
    pickup_next = !(|hi_next)
      && (|above_next)
      && (|below_next)
      && minmax_ok_next
      && seq_ok_next
      && ((res_sel_reg == ctw_pkg::CTW_RES_NONE) || diff_ok_next);
  end

  // Condition flags advance once per program cycle.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      hi_reg <= '0;
      above_reg <= '0;
      below_reg <= '0;
      minmax_ok_reg <= 1'b0;
      seq_ok_reg <= 1'b0;
      diff_ok_reg <= 1'b0;
    end else if (tick_reg) begin
      hi_reg <= hi_next;
      above_reg <= above_next;
      below_reg <= below_next;
      minmax_ok_reg <= minmax_ok_next;
      seq_ok_reg <= seq_ok_next;
      diff_ok_reg <= diff_ok_next;
    end
  end

  // Definite delay supervision sequence, evaluated at each program cycle.
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    if (!pickup_next) begin
      state_next = ctw_pkg::CTW_IDLE;
      timer_next = '0;
    end else if (blk_cycle_reg) begin
      state_next = ctw_pkg::CTW_BLOCKED;
      timer_next = '0;
    end else begin
      unique case (state_reg)
        ctw_pkg::CTW_IDLE, ctw_pkg::CTW_BLOCKED: begin
          timer_next = '0;
          state_next = (delay_reg == '0) ? ctw_pkg::CTW_ALARM : ctw_pkg::CTW_TIMING;
        end
        ctw_pkg::CTW_TIMING: begin
          if (19'(timer_reg + 19'h0_0001) >= delay_reg) begin
            state_next = ctw_pkg::CTW_ALARM;
          end else begin
            timer_next = timer_reg + 19'h0_0001;
          end
        end
        ctw_pkg::CTW_ALARM: state_next = ctw_pkg::CTW_ALARM;
        default: begin
          state_next = ctw_pkg::CTW_IDLE;
          timer_next = '0;
        end
      endcase
    end
  end

  // State, timer and indication outputs.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_reg <= ctw_pkg::CTW_IDLE;
      timer_reg <= '0;
      start_out <= 1'b0;
      alarm_out <= 1'b0;
      blocked_out <= 1'b0;
    end else if (tick_reg) begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      start_out <= (state_next == ctw_pkg::CTW_TIMING) || (state_next == ctw_pkg::CTW_ALARM);
      alarm_out <= state_next == ctw_pkg::CTW_ALARM;
      blocked_out <= state_next == ctw_pkg::CTW_BLOCKED;
    end
  end

  // Register read port, data stands in the cycle after the strobe.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      unique case (addr_in)
        `CTW_ADDR_CTRL: rdata_out <= {28'h000_0000, 1'b0, res_sub_reg, res_sel_reg};
        `CTW_ADDR_HIGH: rdata_out <= {16'h0000, high_reg};
        `CTW_ADDR_LOW: rdata_out <= {16'h0000, low_reg};
        `CTW_ADDR_MINMAX: rdata_out <= {16'h0000, minmax_reg};
        `CTW_ADDR_SEQ: rdata_out <= {16'h0000, seq_reg};
        `CTW_ADDR_DIFF: rdata_out <= {16'h0000, diff_reg};
        `CTW_ADDR_DELAY: rdata_out <= {13'h0000, delay_reg};
        `CTW_ADDR_STATUS: rdata_out <= {
          12'h000, timer_reg[15:0], state_reg
        };
        `CTW_ADDR_DIFF_MAG: rdata_out <= {16'h0000, diff_mag_reg};
        `CTW_ADDR_NAT_ANG: rdata_out <= 32'(comp_ang_reg);
        `CTW_ADDR_DIFF_ANG: rdata_out <= 32'(diff_ang_reg);
        default: rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

endmodule

//--- tb/ctw_supervisor_sva.sv
// Port-level assertion checker for the supervision block, with its bind.
`timescale 1ns/100ps
module ctw_supervisor_sva (
  input wire logic clk_in, // System clock.
  input wire logic rstn_in, // Synchronous reset, active low.
  input wire logic [3:0] addr_in, // Register word address.
  input wire logic rd_in, // Read strobe.
  input wire logic [31:0] rdata_out, // Read data.
  input wire logic start_out, // Start level.
  input wire logic alarm_out, // Alarm level.
  input wire logic blocked_out // Blocked level.
);
  // Every check runs on the system clock and sleeps through reset.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  // Output relations, and levels that may only move at program cycle boundaries.
  chk_alarm_needs_start: assert property (alarm_out |-> start_out)
    else $error("alarm high without start");
  chk_block_excludes: assert property (blocked_out |-> !start_out && !alarm_out)
    else $error("blocked together with start or alarm");
  chk_start_held: assert property ($rose(start_out) |=> $stable(start_out) [*8])
    else $error("start moved inside a program cycle");
  chk_blocked_held: assert property ($rose(blocked_out) |=> $stable(blocked_out) [*8])
    else $error("blocked moved inside a program cycle");
  chk_release_clears: assert property ($fell(start_out) |-> !alarm_out)
    else $error("alarm kept after start fell");

  // Read path: idle zero, unmapped zero, self-clearing command, value spans.
  chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  chk_unmapped_zero: assert property (rd_in && addr_in > 4'ha |=> rdata_out == 32'h0000_0000)
    else $error("unmapped address read nonzero");
  chk_comp_selfclr: assert property (rd_in && addr_in == 4'h0 |=> !rdata_out[3])
    else $error("compensation bit reads one");
  chk_diff_clamp: assert property (rd_in && addr_in == 4'h8 |=> rdata_out <= 32'h0000_1388)
    else $error("difference magnitude above its span");
  chk_angle_span: assert property (rd_in && (addr_in == 4'h9 || addr_in == 4'ha) |=>
    $signed(rdata_out) <= 32'sh0000_8ca0 && $signed(rdata_out) >= -32'sh0000_8ca0)
    else $error("angle outside its span");
endmodule

bind ctw_supervisor ctw_supervisor_sva u_ctw_supervisor_sva (.clk_in, .rstn_in, .addr_in, .rd_in, .rdata_out,
  .start_out, .alarm_out, .blocked_out);

//--- tb/ctw_front_end.sv
// Behavioural phase and residual measurement front end.
`timescale 1ns/100ps
module ctw_front_end (
  input wire logic clk_in, // System clock.
  input wire logic [2:0][15:0] mag_in, // Phase magnitudes, 0.01 x nominal.
  input wire logic trk_in, // High when the residual CT sees the true residual.
  output ctw_pkg::ctw_meas_type meas_out // Measurement record.
);
  logic [15:0] hi;
  logic [15:0] lo;
  logic [15:0] re_sum;
  logic [15:0] im_b;
  logic [15:0] im_c;

  // Spread of the magnitudes and the phasor sum, phases 120 degrees apart.
  always_comb begin
    hi = mag_in[0];
    lo = mag_in[0];
    for (int i = 1; i < 3; i++) begin
      if (mag_in[i] > hi) hi = mag_in[i];
      if (mag_in[i] < lo) lo = mag_in[i];
    end
    im_b = 16'((32'(mag_in[1]) * 32'h0000_0377) >> 10);
    im_c = 16'((32'(mag_in[2]) * 32'h0000_0377) >> 10);
    re_sum = mag_in[0] - (mag_in[1] >> 1) - (mag_in[2] >> 1);
  end

  // A lost phase gives 50 percent unbalance; a healthy residual CT reads minus the phase sum.
  always_ff @(posedge clk_in) begin
    meas_out.phase_mag <= mag_in;
    meas_out.pos_mag <= 16'((32'(mag_in[0]) + mag_in[1] + mag_in[2]) / 32'h0000_0003);
    meas_out.neg_mag <= (hi - lo) / 16'h0003;
    meas_out.phase_re <= {-(mag_in[2] >> 1), -(mag_in[1] >> 1), mag_in[0]};
    meas_out.phase_im <= {-im_c, im_b, 16'h0000};
    meas_out.res1_re <= trk_in ? -re_sum : 16'h0000;
    meas_out.res1_im <= trk_in ? im_c - im_b : 16'h0000;
    meas_out.res2_re <= trk_in ? -re_sum : 16'h0000;
    meas_out.res2_im <= trk_in ? im_c - im_b : 16'h0000;
    meas_out.sum_ang <= 17'h0_1770;
    meas_out.res1_ang <= 17'h0_0000;
    meas_out.res2_ang <= 17'h0_0000;
  end
endmodule

//--- tb/tb_ctw_supervisor.sv
// Self-checking bench for the supervision block.
`timescale 1ns/100ps
`include "ctw_defs.svh"
module tb_ctw_supervisor;
  localparam int CYC = 50;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [1:0] sel;
    logic sub;
    logic trk;
    logic blk;
    logic [2:0] exp;
  } ctw_row_type;
  localparam ctw_row_type ROWS [9] = '{
    '{16'h0064, 16'h0064, 16'h0064, 2'h0, 1'b0, 1'b0, 1'b0, 3'h0},
    '{16'h0064, 16'h0064, 16'h0000, 2'h0, 1'b0, 1'b0, 1'b0, 3'h6},
    '{16'h0064, 16'h0064, 16'h0000, 2'h0, 1'b0, 1'b0, 1'b1, 3'h1},
    '{16'h0082, 16'h0064, 16'h0000, 2'h0, 1'b0, 1'b0, 1'b0, 3'h0},
    '{16'h0005, 16'h0005, 16'h0000, 2'h0, 1'b0, 1'b0, 1'b0, 3'h0},
    '{16'h0064, 16'h0064, 16'h0000, 2'h1, 1'b0, 1'b1, 1'b0, 3'h0},
    '{16'h0064, 16'h0064, 16'h0000, 2'h1, 1'b0, 1'b0, 1'b0, 3'h6},
    '{16'h0064, 16'h0064, 16'h0000, 2'h1, 1'b1, 1'b1, 1'b0, 3'h6},
    '{16'h0064, 16'h0000, 16'h0064, 2'h2, 1'b0, 1'b0, 1'b0, 3'h6}};
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic block_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic start_out;
  logic alarm_out;
  logic blocked_out;
  logic [2:0][15:0] mag = {16'h0064, 16'h0064, 16'h0064};
  logic trk = 1'b0;
  ctw_pkg::ctw_meas_type meas;
  logic [31:0] d;
  int error_cnt = 0;
  int comparisons = 0;
  int n;

  ctw_front_end u_ctw_front_end (.clk_in(clk_in), .mag_in(mag), .trk_in(trk), .meas_out(meas));
  ctw_supervisor #(.CYCLE_CLKS(CYC)) u_ctw_supervisor (.clk_in(clk_in), .rstn_in(rstn_in), .meas_in(meas),
    .block_in(block_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .start_out(start_out), .alarm_out(alarm_out), .blocked_out(blocked_out));

  // The 50 MHz system clock.
  initial begin
    forever #10 clk_in = ~clk_in;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle register write and read; read data stand in the cycle after the strobe.
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask

  // Waits whole program cycles, then lets the edge settle.
  task automatic ticks(input int k);
    repeat (k * CYC) @(posedge clk_in);
    #1;
  endtask

  // Counts edges until start or alarm is seen high, bounded.
  task automatic await_rise(input bit alm, output int k);
    for (k = 0; k < 10 * CYC; k++) begin
      @(posedge clk_in);
      if ((alm ? alarm_out : start_out) === 1'b1) break;
    end
    if (k == 10 * CYC) begin
      error_cnt++;
      $display("ERROR %0t wait ran out", $time);
      conclude();
    end
  endtask

  // Main sequence: table rows, then reset, timing, hysteresis and residual cases.
  initial begin
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    wr(4'h6, 32'h0000_0002);
    foreach (ROWS[i]) begin
      wr(4'h0, {29'h0, ROWS[i].sub, ROWS[i].sel});
      mag <= {ROWS[i].c, ROWS[i].b, ROWS[i].a};
      trk <= ROWS[i].trk;
      block_in <= ROWS[i].blk;
      ticks(6);
      check({29'h0, start_out, alarm_out, blocked_out}, {29'h0, ROWS[i].exp}, "row");
    end
    @(posedge clk_in);
    block_in <= 1'b0;
    wr(4'h0, 32'h0000_0000);
    rstn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    #1 check({29'h0, start_out, alarm_out, blocked_out}, 32'h0000_0000, "reset outputs");
    for (int i = 1; i < 7; i++) begin
      rd(4'(i), d);
      case (i)
        1: check(d, 32'(`CTW_RST_HIGH), "high default");
        2: check(d, 32'(`CTW_RST_LOW), "low default");
        3: check(d, 32'(`CTW_RST_MINMAX), "ratio default");
        4: check(d, 32'(`CTW_RST_SEQ), "sequence default");
        5: check(d, 32'(`CTW_RST_DIFF), "difference default");
        default: check(d, 32'(`CTW_RST_DELAY), "delay default");
      endcase
    end
    rd(4'h7, d);
    check({28'h0, d[3:0]}, 32'h0000_0001, "idle status");
    rd(4'hf, d);
    check(d, 32'h0000_0000, "unmapped read");
    wr(4'h6, 32'h0000_0003);
    mag <= {16'h0000, 16'h0064, 16'h0064};
    await_rise(1'b0, n);
    ticks(2);
    mag <= {16'h0064, 16'h0064, 16'h0064};
    ticks(2);
    check({30'h0, start_out, alarm_out}, 32'h0000_0000, "interrupted fault");
    mag <= {16'h0000, 16'h0064, 16'h0064};
    await_rise(1'b0, n);
    await_rise(1'b1, n);
    check(32'(n + 1), 32'(3 * CYC), "alarm delay");
    mag <= {16'h0000, 16'h0064, 16'h007d};
    ticks(3);
    check({30'h0, start_out, alarm_out}, 32'h0000_0000, "over high limit");
    mag <= {16'h0000, 16'h0064, 16'h0076};
    ticks(6);
    check({30'h0, start_out, alarm_out}, 32'h0000_0000, "high hysteresis hold");
    mag <= {16'h0000, 16'h0064, 16'h006e};
    ticks(6);
    check({30'h0, start_out, alarm_out}, 32'h0000_0003, "high hysteresis release");
    mag <= {16'h0000, 16'h0064, 16'h0064};
    wr(4'h0, 32'h0000_0001);
    ticks(3);
    rd(4'h8, d);
    check({31'h0, d >= 32'h0000_0062 && d <= 32'h0000_0064}, 32'h0000_0001, "difference magnitude");
    rd(4'ha, d);
    check(d, 32'h0000_1770, "angle difference");
    wr(4'h0, 32'h0000_0009);
    rd(4'h9, d);
    check(d, 32'h0000_1770, "natural angle");
    rd(4'h0, d);
    check(d, 32'h0000_0001, "control readback");
    ticks(6);
    check({30'h0, start_out, alarm_out}, 32'h0000_0000, "compensated residual");
    conclude();
  end
endmodule
